// ### shared/strap_cfg_pkg.sv
package strap_cfg_pkg;
   localparam int NUM_PINS   = 8;
   localparam int PIN_BITS   = 4;
   localparam int PIN_SPEED  = 7;
   localparam int PIN_MISC   = 6;
   localparam int PIN_CLK    = 5;
   localparam int PIN_MED1   = 4;
   localparam int PIN_MED0   = 3;
   localparam int B_MSB      = 3;
   localparam int B_DNSHIFT  = 2;
   localparam int B_MACAN    = 3;
   localparam int B_LOWPWR   = 2;
   localparam int B_ASYM     = 1;
   localparam int B_SYM      = 0;
   localparam int B_CLKFREQ  = 1;
   localparam int B_CLKEN    = 0;
   localparam int SYNC_DEPTH = 2;

   // APB register offsets
   localparam logic [11:0] OFF_ADV    = 12'h000;
   localparam logic [11:0] OFF_GIGADV = 12'h004;
   localparam logic [11:0] OFF_MEDIA  = 12'h008;
   localparam logic [11:0] OFF_MISC   = 12'h00c;
   localparam logic [11:0] OFF_STRAP0 = 12'h010;
   localparam logic [11:0] OFF_STRAP1 = 12'h014;

   // Field positions inside the registers
   localparam int F_ADV_LO    = 5;
   localparam int F_ASYM      = 11;
   localparam int F_SYM       = 10;
   localparam int F_GIG_LO    = 8;
   localparam int F_MEDIA_LO  = 8;
   localparam int F_MACAN     = 13;
   localparam int F_DNSHIFT   = 4;
   localparam int F_CLKFREQ   = 8;
   localparam int F_CLKEN     = 0;
   localparam int F_LOWPWR    = 6;
   localparam int F_AUTOSENSE = 16;

   typedef enum logic [2:0] {
      MEDIA_COPPER   = 3'h0,
      MEDIA_PASSTHRU = 3'h1,
      MEDIA_FIB1000  = 3'h2,
      MEDIA_FIB100   = 3'h3,
      MEDIA_RESERVED = 3'h4,
      MEDIA_AS_PASS  = 3'h5,
      MEDIA_AS_1000  = 3'h6,
      MEDIA_AS_100   = 3'h7
   } media_t;

   typedef struct packed {
      logic [3:0] advSpeed;    // Reg 4 bits 8:5 (100F,100H,10F,10H)
      logic [1:0] advGig;      // Reg 9 bits 9:8 (1000F,1000H)
      logic       asymPause;
      logic       symPause;
      logic       macAutoNeg;
      logic       lowPowerLinkMode;
      logic       downshiftEn;
      logic       auxClockFreqSel;
      logic       auxClockOutputEn;
      media_t     media;
   } cfg_t;

   typedef struct packed {
      logic        fiberOnly;
      logic        autoSense;
      logic        fiberPhyAutoNeg;
      logic        fiber100;
      logic        fiberPassThru;
   } media_mode_t;

   localparam logic [3:0] ADV_ALL    = 4'hf;
   localparam logic [1:0] GIG_ALL    = 2'h3;
   localparam logic [3:0] ADV_FDXGIG = 4'hb;
   localparam logic [1:0] GIG_FDX    = 2'h2;
   localparam logic [3:0] ADV_NONE   = 4'h0;
   localparam logic [1:0] GIG_NONE   = 2'h0;
endpackage : strap_cfg_pkg

// ### design/strap_decode.sv
`timescale 1ns/1ps
`default_nettype none
module strap_decode
(
   input  wire logic [15:0]         pinsHi,   // Straps 7..4, 4 bits each
   input  wire logic [3:0]          pin3,     // Strap 3
   output var strap_cfg_pkg::cfg_t  cfg       // Decoded defaults
);
   localparam int W = strap_cfg_pkg::PIN_BITS;
   localparam int O7 = (strap_cfg_pkg::PIN_SPEED - strap_cfg_pkg::PIN_MED1)
                       * W;
   localparam int O6 = (strap_cfg_pkg::PIN_MISC - strap_cfg_pkg::PIN_MED1)
                       * W;
   localparam int O5 = (strap_cfg_pkg::PIN_CLK - strap_cfg_pkg::PIN_MED1)
                       * W;

   always_comb
   begin
      unique case (pinsHi[O7 +: 2])
         2'h0:
         begin
            cfg.advSpeed = strap_cfg_pkg::ADV_ALL;
            cfg.advGig   = strap_cfg_pkg::GIG_ALL;
         end
         2'h1:
         begin
            cfg.advSpeed = strap_cfg_pkg::ADV_ALL;
            cfg.advGig   = strap_cfg_pkg::GIG_FDX;
         end
         2'h2:
         begin
            cfg.advSpeed = strap_cfg_pkg::ADV_NONE;
            cfg.advGig   = strap_cfg_pkg::GIG_FDX;
         end
         2'h3:
         begin
            cfg.advSpeed = strap_cfg_pkg::ADV_ALL;
            cfg.advGig   = strap_cfg_pkg::GIG_NONE;
         end
      endcase
      cfg.downshiftEn      = pinsHi[O7 + strap_cfg_pkg::B_DNSHIFT];
      cfg.macAutoNeg       = pinsHi[O6 + strap_cfg_pkg::B_MACAN];
      cfg.lowPowerLinkMode = pinsHi[O6 + strap_cfg_pkg::B_LOWPWR];
      cfg.auxClockOutputEn = pinsHi[O5 + strap_cfg_pkg::B_CLKEN];
      cfg.asymPause        = pinsHi[O6 + strap_cfg_pkg::B_ASYM];
      cfg.symPause         = pinsHi[O6 + strap_cfg_pkg::B_SYM];
      cfg.auxClockFreqSel  = pinsHi[O5 + strap_cfg_pkg::B_CLKFREQ];
      cfg.media = strap_cfg_pkg::media_t'({pinsHi[O5 + strap_cfg_pkg::B_MSB],
                                   pinsHi[strap_cfg_pkg::B_MSB],
                                   pin3[strap_cfg_pkg::B_MSB]});
   end
endmodule : strap_decode
`default_nettype wire

// ### design/strap_config_defaults_loader.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module strap_config_defaults_loader
#(
   parameter int NUM_PINS = strap_cfg_pkg::NUM_PINS,
   parameter int PIN_BITS = strap_cfg_pkg::PIN_BITS
)
(
   input  wire logic                        mclk,       // 10 MHz clock
   input  wire logic                        rst,        // Async reset
   input  wire logic                        clkEn,      // Freezes state
   input  wire logic [NUM_PINS*PIN_BITS-1:0] strapPins, // Pin n at n*4
   input  wire logic                        psel,       // APB select
   input  wire logic                        penable,    // APB enable
   input  wire logic                        pwrite,     // APB direction
   input  wire logic [11:0]                 paddr,      // APB address
   input  wire logic [31:0]                 pwdata,     // APB write data
   output logic      [31:0]                 prdata,     // APB read data
   output logic                             pready,     // APB ready
   output logic                             pslverr,    // APB error
   output var strap_cfg_pkg::cfg_t          cfgOut,     // Live fields
   output var strap_cfg_pkg::media_mode_t   mediaMode,  // Media decode
   output logic                             cfgValid    // Defaults loaded
);
   // ****************************************************
   // Strap synchronisers
   // ****************************************************
   localparam int N = NUM_PINS * PIN_BITS;
   logic [N-1:0] sync1_reg, sync2_reg;
   logic [N-1:0] sync1_next, sync2_next;

   always_comb
   begin
      sync1_next = clkEn ? strapPins : sync1_reg;
      sync2_next = clkEn ? sync1_reg : sync2_reg;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // ****************************************************
   // Decode
   // ****************************************************
   strap_cfg_pkg::cfg_t decoded;
   strap_decode u_decode
   (
      .pinsHi (sync2_reg[strap_cfg_pkg::PIN_MED1*PIN_BITS +: 16]),
      .pin3   (sync2_reg[strap_cfg_pkg::PIN_MED0*PIN_BITS +: 4]),
      .cfg    (decoded)
   );

   // ****************************************************
   // Capture and register file
   // ****************************************************
   // Straps settle through the synchroniser while loading; the capture
   // waits for SYNC_DEPTH+1 enabled clocks after release so no reset value leaks.
   typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} load_state_t;
   load_state_t state_reg, state_next;
   logic [1:0]  cnt_reg, cnt_next;
   strap_cfg_pkg::cfg_t cfg_reg, cfg_next;
   logic [N-1:0] snap_reg, snap_next;

   logic access;
   assign access = psel && penable;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      cfg_next   = cfg_reg;
      snap_next  = snap_reg;
      if (clkEn)
      begin
         unique case (state_reg)
            ST_SETTLE:
            begin
               cnt_next = cnt_reg + 2'h1;
               if (cnt_reg == 2'(strap_cfg_pkg::SYNC_DEPTH))
                  state_next = ST_LOAD;
            end
            ST_LOAD:
            begin
               cfg_next   = decoded;
               snap_next  = sync2_reg;
               state_next = ST_RUN;
            end
            ST_RUN:
            begin
               if (access && pready && pwrite)
               begin
                  if (hit(paddr, strap_cfg_pkg::OFF_ADV))
                  begin
                     cfg_next.advSpeed  = pwdata[strap_cfg_pkg::F_ADV_LO +: 4];
                     cfg_next.asymPause = pwdata[strap_cfg_pkg::F_ASYM];
                     cfg_next.symPause  = pwdata[strap_cfg_pkg::F_SYM];
                  end
                  if (hit(paddr, strap_cfg_pkg::OFF_GIGADV))
                     cfg_next.advGig = pwdata[strap_cfg_pkg::F_GIG_LO +: 2];
                  if (hit(paddr, strap_cfg_pkg::OFF_MEDIA))
                  begin
                     cfg_next.media = strap_cfg_pkg::media_t'(
                        pwdata[strap_cfg_pkg::F_MEDIA_LO +: 3]);
                     cfg_next.macAutoNeg = pwdata[strap_cfg_pkg::F_MACAN];
                  end
                  if (hit(paddr, strap_cfg_pkg::OFF_MISC))
                  begin
                     cfg_next.downshiftEn =
                        pwdata[strap_cfg_pkg::F_DNSHIFT];
                     cfg_next.auxClockFreqSel =
                        pwdata[strap_cfg_pkg::F_CLKFREQ];
                     cfg_next.auxClockOutputEn =
                        pwdata[strap_cfg_pkg::F_CLKEN];
                     cfg_next.lowPowerLinkMode =
                        pwdata[strap_cfg_pkg::F_LOWPWR];
                  end
               end
            end
            default: state_next = ST_SETTLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_SETTLE;
         cnt_reg   <= '0;
         cfg_reg   <= '0;
         snap_reg  <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         cfg_reg   <= cfg_next;
         snap_reg  <= snap_next;
      end
   end

   // ****************************************************
   // Media mode decode
   // ****************************************************
   always_comb
   begin
      mediaMode = '0;
      unique case (cfg_reg.media)
         strap_cfg_pkg::MEDIA_COPPER:   ;
         strap_cfg_pkg::MEDIA_PASSTHRU:
         begin
            mediaMode.fiberOnly     = 1'b1;
            mediaMode.fiberPassThru = 1'b1;
         end
         strap_cfg_pkg::MEDIA_FIB1000:
         begin
            mediaMode.fiberOnly       = 1'b1;
            mediaMode.fiberPhyAutoNeg = 1'b1;
         end
         strap_cfg_pkg::MEDIA_FIB100:
         begin
            mediaMode.fiberOnly = 1'b1;
            mediaMode.fiber100  = 1'b1;
         end
         // Reserved code: no mode; board must not strap it
         strap_cfg_pkg::MEDIA_RESERVED: ;
         strap_cfg_pkg::MEDIA_AS_PASS:
         begin
            mediaMode.autoSense     = 1'b1;
            mediaMode.fiberPassThru = 1'b1;
         end
         strap_cfg_pkg::MEDIA_AS_1000:
         begin
            mediaMode.autoSense       = 1'b1;
            mediaMode.fiberPhyAutoNeg = 1'b1;
         end
         strap_cfg_pkg::MEDIA_AS_100:
         begin
            mediaMode.autoSense = 1'b1;
            mediaMode.fiber100  = 1'b1;
         end
      endcase
   end

   // ****************************************************
   // APB read side
   // ****************************************************
   logic        known;
   logic [31:0] rdMux;
   logic [31:0] rdData_reg, rdData_next;
   logic        rdOk_reg, rdOk_next;
   always_comb
   begin
      rdMux = '0;
      known = 1'b1;
      if (hit(paddr, strap_cfg_pkg::OFF_ADV))
      begin
         rdMux[strap_cfg_pkg::F_ADV_LO +: 4] = cfg_reg.advSpeed;
         rdMux[strap_cfg_pkg::F_ASYM]        = cfg_reg.asymPause;
         rdMux[strap_cfg_pkg::F_SYM]         = cfg_reg.symPause;
      end
      else if (hit(paddr, strap_cfg_pkg::OFF_GIGADV))
         rdMux[strap_cfg_pkg::F_GIG_LO +: 2] = cfg_reg.advGig;
      else if (hit(paddr, strap_cfg_pkg::OFF_MEDIA))
      begin
         rdMux[strap_cfg_pkg::F_MEDIA_LO +: 3] = cfg_reg.media;
         rdMux[strap_cfg_pkg::F_MACAN]         = cfg_reg.macAutoNeg;
         rdMux[strap_cfg_pkg::F_AUTOSENSE]     = mediaMode.autoSense;
      end
      else if (hit(paddr, strap_cfg_pkg::OFF_MISC))
      begin
         rdMux[strap_cfg_pkg::F_DNSHIFT] = cfg_reg.downshiftEn;
         rdMux[strap_cfg_pkg::F_CLKFREQ] = cfg_reg.auxClockFreqSel;
         rdMux[strap_cfg_pkg::F_CLKEN]   = cfg_reg.auxClockOutputEn;
         rdMux[strap_cfg_pkg::F_LOWPWR]  = cfg_reg.lowPowerLinkMode;
      end
      else if (hit(paddr, strap_cfg_pkg::OFF_STRAP0))
         rdMux = snap_reg[31:0];
      else if (hit(paddr, strap_cfg_pkg::OFF_STRAP1))
         rdMux = '0;
      else
         known = 1'b0;
   end

   // Read word is registered at an enabled edge of the transfer; rdOk
   // stops a frozen setup edge from answering with a stale word
   always_comb
   begin
      rdData_next = clkEn ? rdMux : rdData_reg;
      rdOk_next   = rdOk_reg;
      if (clkEn)
         rdOk_next = psel && (state_reg == ST_RUN) && !(access && pready);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rdData_reg <= '0;
         rdOk_reg   <= 1'b0;
      end
      else
      begin
         rdData_reg <= rdData_next;
         rdOk_reg   <= rdOk_next;
      end
   end

   // Writes before load would be lost, so the bus stalls until then
   assign pready   = (state_reg == ST_RUN) && clkEn && rdOk_reg;
   assign prdata   = rdData_reg;
   assign pslverr  = access && pready && !known;
   assign cfgOut   = cfg_reg;
   assign cfgValid = (state_reg == ST_RUN);

   a_load_after_settle: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == ST_LOAD && clkEn) |=>
      cfgValid && cfg_reg == $past(decoded))
      else $error("defaults not loaded from straps");
   a_media_autosense: assert property (@(posedge mclk) disable iff (rst)
      mediaMode.autoSense == (cfg_reg.media[2] && cfg_reg.media != 3'h4))
      else $error("autosense mismatch");
   a_media_fiber100: assert property (@(posedge mclk) disable iff (rst)
      mediaMode.fiber100 == (cfg_reg.media[1:0] == 2'h3))
      else $error("100 fiber mismatch");
   a_media_pass: assert property (@(posedge mclk) disable iff (rst)
      mediaMode.fiberPassThru == (cfg_reg.media[1:0] == 2'h1))
      else $error("pass-through mismatch");
   a_copper_only: assert property (@(posedge mclk) disable iff (rst)
      (cfg_reg.media == 3'h0) |-> mediaMode == '0)
      else $error("copper mode not plain");
   a_downshift_pin: assert property (@(posedge mclk) disable iff (rst)
      decoded.downshiftEn == sync2_reg[30])
      else $error("downshift bit wrong");
   a_pause_pins: assert property (@(posedge mclk) disable iff (rst)
      {decoded.asymPause, decoded.symPause} == sync2_reg[25:24])
      else $error("pause bits wrong");
   a_speed_gig: assert property (@(posedge mclk) disable iff (rst)
      (sync2_reg[29:28] == 2'h2) |-> decoded.advSpeed == 4'h0 &&
      decoded.advGig == 2'h2)
      else $error("gig-only advert wrong");
   a_clk_pins: assert property (@(posedge mclk) disable iff (rst)
      {decoded.auxClockFreqSel, decoded.auxClockOutputEn} == sync2_reg[21:20])
      else $error("aux clock bits wrong");
   a_enables_pins: assert property (@(posedge mclk) disable iff (rst)
      {decoded.macAutoNeg, decoded.lowPowerLinkMode} == sync2_reg[27:26])
      else $error("enable bits wrong");
endmodule : strap_config_defaults_loader
`default_nettype wire

// ### bench/strap_resistor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Board strap resistors seen as sensed pin levels
// ************************************************************
module strap_resistor_model
(
   input  wire logic [7:0][3:0] pinLevel,  // Level chosen per pin
   output logic      [31:0]     strapPins  // Sensed straps, pin n at 4n
);
   // Reserved strap bits 31 and 22 are always fitted as logic 0 on the board
   always_comb
   begin
      strapPins     = pinLevel;
      strapPins[31] = 1'b0;
      strapPins[22] = 1'b0;
   end
endmodule : strap_resistor_model
`default_nettype wire

// ### bench/strap_config_defaults_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
module strap_config_defaults_loader_tb;
   logic                       mclk;
   logic                       rst;
   logic                       clkEn;
   logic                       psel;
   logic                       penable;
   logic                       pwrite;
   logic                       pready;
   logic                       pslverr;
   logic                       cfgValid;
   logic                       err;
   logic [11:0]                paddr;
   logic [31:0]                pwdata;
   logic [31:0]                prdata;
   logic [31:0]                strapPins;
   logic [31:0]                rd;
   logic [7:0][3:0]            pinLevel;
   strap_cfg_pkg::cfg_t        cfgOut;
   strap_cfg_pkg::cfg_t        ec;
   strap_cfg_pkg::media_mode_t mediaMode;
   int                         errors;
   int                         checked;

   strap_resistor_model u_strap_resistor_model
   (
      .pinLevel  (pinLevel),
      .strapPins (strapPins)
   );

   strap_config_defaults_loader u_strap_config_defaults_loader
   (
      .mclk      (mclk),
      .rst       (rst),
      .clkEn     (clkEn),
      .strapPins (strapPins),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .cfgOut    (cfgOut),
      .mediaMode (mediaMode),
      .cfgValid  (cfgValid)
   );

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Outputs are read in the active region of the edge, before any flop
   // or bench input moves, so they hold the values that edge samples
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         errors++;
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask : rdchk

   // ************************************************************
   // Expected decode, worked out from the strap meanings
   // ************************************************************
   function automatic strap_cfg_pkg::cfg_t dec(input logic [31:0] s);
      strap_cfg_pkg::cfg_t c;
      c = '0;
      case (s[29:28])
         2'h0: {c.advSpeed, c.advGig} = 6'h3f;
         2'h1: {c.advSpeed, c.advGig} = 6'h3e;
         2'h2: {c.advSpeed, c.advGig} = 6'h02;
         default: {c.advSpeed, c.advGig} = 6'h3c;
      endcase
      c.downshiftEn      = s[30];
      c.macAutoNeg       = s[27];
      c.lowPowerLinkMode = s[26];
      c.asymPause        = s[25];
      c.symPause         = s[24];
      c.auxClockFreqSel  = s[21];
      c.auxClockOutputEn = s[20];
      c.media = strap_cfg_pkg::media_t'({s[23], s[19], s[15]});
      return c;
   endfunction : dec

   function automatic strap_cfg_pkg::media_mode_t mmode(input logic [2:0] m);
      mmode                 = '0;
      mmode.fiberOnly       = m == 3'h1 || m == 3'h2 || m == 3'h3;
      mmode.autoSense       = m > 3'h4;
      mmode.fiberPhyAutoNeg = m[1:0] == 2'h2;
      mmode.fiber100        = m[1:0] == 2'h3;
      mmode.fiberPassThru   = m[1:0] == 2'h1;
   endfunction : mmode

   // Noise on unrelated strap bits must not leak into any field
   function automatic logic [31:0] mk(input int i);
      logic [3:0] b;
      logic [2:0] m;
      b  = 4'(i);
      m  = (i < 4) ? 3'(i) : 3'(i + 1);
      mk = {1'b0, b[0], b[1:0], b[1], b[2], ~b[0], b[1] ^ b[2],
            m[2], 1'b0, b[2], ~b[1], m[1], 3'h6, m[0], 3'h3, 12'ha5c};
   endfunction : mk

   task automatic regs(input strap_cfg_pkg::cfg_t c, input logic [31:0] s);
      rdchk(strap_cfg_pkg::OFF_ADV, {20'h0, c.asymPause, c.symPause,
            1'b0, c.advSpeed, 5'h0});
      rdchk(strap_cfg_pkg::OFF_GIGADV, {22'h0, c.advGig, 8'h0});
      rdchk(strap_cfg_pkg::OFF_MEDIA, {15'h0, c.media > 3'h4, 2'h0,
            c.macAutoNeg, 2'h0, c.media, 8'h0});
      rdchk(strap_cfg_pkg::OFF_MISC, {23'h0, c.auxClockFreqSel, 1'b0,
            c.lowPowerLinkMode, 1'b0, c.downshiftEn, 3'h0,
            c.auxClockOutputEn});
      rdchk(strap_cfg_pkg::OFF_STRAP0, s);
      rdchk(strap_cfg_pkg::OFF_STRAP1, 32'h0);
      rdchk(12'h018, 32'h0);
      cmp({31'h0, err}, 32'h1);
   endtask : regs

   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      end_sim();
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial
   begin
      rst      = 1'b1;
      clkEn    = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      pinLevel = mk(0);
      errors   = 0;
      checked  = 0;
      for (int i = 0; i < 7; i++)
      begin
         @(posedge mclk);
         pinLevel <= mk(i);
         rst      <= 1'b1;
         repeat (6) @(posedge mclk);
         rst <= 1'b0;
         if (i == 0)
         begin
            repeat (10) @(negedge mclk);
            cmp({30'h0, pready, cfgValid}, 32'h0);
            @(posedge mclk);
            clkEn <= 1'b1;
         end
         for (int n = 0; n < 30 && cfgValid !== 1'b1; n++)
            @(negedge mclk);
         cmp({31'h0, cfgValid}, 32'h1);
         ec = dec(mk(i));
         cmp(32'(cfgOut), 32'(ec));
         cmp(32'(mediaMode), 32'(mmode(ec.media)));
         regs(ec, mk(i));
         pinLevel <= mk(6 - i);
         repeat (4) @(negedge mclk);
         cmp(32'(cfgOut), 32'(ec));
      end
      // Management writes take over from the strap defaults
      apb(1'b1, strap_cfg_pkg::OFF_ADV, 32'h0000_0460);
      apb(1'b1, strap_cfg_pkg::OFF_MISC, 32'h0000_0151);
      apb(1'b1, strap_cfg_pkg::OFF_MEDIA, 32'h0000_2600);
      apb(1'b1, strap_cfg_pkg::OFF_GIGADV, 32'h0000_0100);
      apb(1'b1, strap_cfg_pkg::OFF_STRAP0, 32'h0);
      apb(1'b1, 12'h018, 32'hffff_ffff);
      ec = '{4'h3, 2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
             strap_cfg_pkg::MEDIA_AS_1000};
      @(negedge mclk);
      cmp(32'(cfgOut), 32'(ec));
      cmp(32'(mediaMode), 32'(mmode(ec.media)));
      regs(ec, mk(6));
      end_sim();
   end
endmodule : strap_config_defaults_loader_tb
`default_nettype wire
